// ===== common/afw_pkg.sv
// shared constants and types for the graphics-port target block
package afw_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_QSTAT = 8'h0C;
    // field positions
    localparam int CTRL_FASTWR_CAP_BIT = 0;
    localparam int CMD_FASTWR_EN_BIT = 4;
    localparam int STAT_FASTWR_BIT = 4;
    localparam int RATE_1X_BIT = 0;
    localparam int RATE_2X_BIT = 1;
    localparam int RATE_4X_BIT = 2;
    localparam int RATE_W = 3;
    localparam int QSTAT_FENCE_BIT = 8;
    localparam int QSTAT_DROP_LSB = 16;
    // reset values and capabilities
    localparam logic [2:0] RATE_CAPS = 3'h7;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [31:0] LFSR_SEED = 32'h1ACE_B00C;
    localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
    // enhanced command codes
    localparam logic [3:0] CMD_READ = 4'h0;
    localparam logic [3:0] CMD_HP_READ = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_HP_WRITE = 4'h5;
    localparam logic [3:0] CMD_LREAD = 4'h8;
    localparam logic [3:0] CMD_HP_LREAD = 4'h9;
    localparam logic [3:0] CMD_FLUSH = 4'hA;
    localparam logic [3:0] CMD_FENCE = 4'hC;
    // frame-based command codes
    localparam logic [3:0] FCMD_MRD = 4'h6;
    localparam logic [3:0] FCMD_MWR = 4'h7;
    localparam logic [3:0] FCMD_MRM = 4'hC;
    localparam logic [3:0] FCMD_MRL = 4'hE;
    localparam logic [3:0] FCMD_MWI = 4'hF;
    // bytes per link clock per rate
    localparam logic [4:0] BPC_1X = 5'h04;
    localparam logic [4:0] BPC_2X = 5'h08;
    localparam logic [4:0] BPC_4X = 5'h10;
    localparam logic [6:0] BLOCK_BYTES = 7'h40;
    // request kinds on the link
    typedef enum logic [1:0] {AFW_FRAME, AFW_PIPE, AFW_SBA, AFW_NONE} afw_kind_t;
    // write protocol toward the graphics master
    typedef enum logic [1:0] {AFW_W1X, AFW_W2X, AFW_W4X} afw_wmode_t;
    // queued request
    typedef struct packed {
        logic fence;
        logic write;
        logic hipri;
        logic snoop;
        logic be_off;
    } afw_req_t;
endpackage : afw_pkg

// ===== common/afw_q_if.sv
// request queue carrier between the decoder and the queue
`timescale 1ns/1ps
interface afw_q_if #(parameter int CW = 4) ();
    logic push_valid;
    logic push_ready;
    afw_pkg::afw_req_t push_entry;
    logic pop_valid;
    logic pop_ready;
    afw_pkg::afw_req_t pop_entry;
    logic [CW-1:0] count;
    logic fence_held;
    modport owner (output push_valid, push_entry, pop_ready,
                   input push_ready, pop_valid, pop_entry, count, fence_held);
    modport queue (input push_valid, push_entry, pop_ready,
                   output push_ready, pop_valid, pop_entry, count, fence_held);
endinterface : afw_q_if

// ===== logic/afw_req_queue.sv
// in-order request queue; order of entries is never changed
`timescale 1ns/1ps
module afw_req_queue #(
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    afw_q_if.queue q
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || CW < AW + 1) begin : g_bad
            $error("queue depth must be a power of two of at least 2");
        end
    endgenerate

    afw_pkg::afw_req_t mem_reg [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic do_push, do_pop;

    ////////////////////////////////////////////////////////////////////////
    // pointer arithmetic; head always leaves first
    always_comb begin
        do_push = q.push_valid && q.push_ready;
        do_pop = q.pop_valid && q.pop_ready;
        wr_next = wr_reg + (AW+1)'(do_push);
        rd_next = rd_reg + (AW+1)'(do_pop);
    end
    assign q.push_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign q.pop_valid = wr_reg != rd_reg;
    assign q.pop_entry = q.pop_valid ? mem_reg[rd_reg[AW-1:0]] : '0; // head fields read zero while empty
    assign q.count = CW'(wr_reg - rd_reg);
    assign q.fence_held = q.pop_valid && q.pop_entry.fence;

    // pointers and storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wr_reg[AW-1:0]] <= q.push_entry;
        end
    end
endmodule : afw_req_queue

// ===== logic/afw_target.sv
// graphics-port target: command decode, queueing, rate and fast write control
// Operation
// - pipelined and sideband requests to memory are queued without snooping
// - frame-based requests to memory are queued with a snoop
// - pipelined or sideband requests never reach the hub interface
// - frame-based requests from the master to the hub are never forwarded
// - as initiator only frame-based cycles are issued
// - pipelined, sideband and frame requests are accepted interleaved
// - read and long read are low priority; codes 0001 and 1001 high
// - write is low priority, high-priority write is high priority
// - reads decoding to the hub complete locally with random data
// - long reads to the hub complete locally with random data
// - writes to the hub become memory cycles with byte enables off
// - flush completes with one quadword of random data
// - fence gives no data and inserts an ordering flag in the queue
// - all queued requests leave strictly in arrival order, fences hold
// - status rate field advertises 4x in bit 2
// - rate bit 2 set at init selects 4x; rate locks after first setting
// - 4x keeps the same control protocol, only transfers per clock change
// - 4x moves 16 bytes per link clock; block stays 64 bytes
// - 4x enables two data strobe complements and one sideband complement
// - fast writes only with capability and command enables both set
// - capability enable resets to 0; status fast write bit mirrors it
// - fast writes apply to processor and hub writes to the master
// - rate bit 2 gives 4x, bit 1 gives 2x, bit 0 plain writes
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module afw_target #(
    parameter int QDEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic link_clk,
    input wire logic link_req_valid,
    input wire logic [1:0] link_req_kind,
    input wire logic [3:0] link_req_cmd,
    input wire logic link_req_hub,
    output logic link_stall,
    output logic rdata_valid,
    output logic [63:0] rdata_qw,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic mem_req_write,
    output logic mem_req_hipri,
    output logic mem_req_snoop,
    output logic mem_req_be_off,
    output logic mem_req_fence,
    input wire logic wr_in_valid,
    input wire logic wr_in_from_hub,
    output logic wr_out_valid,
    output logic wr_out_from_hub,
    output logic wr_out_frame,
    output logic [1:0] wr_out_mode,
    output logic [1:0] xfer_mode,
    output logic [4:0] xfer_bytes,
    output logic [6:0] block_bytes,
    output logic [2:0] strobe_comp_en
);
    localparam int CW = $clog2(QDEPTH) + 1;

    ////////////////////////////////////////////////////////////////////////
    // link inputs: two flops each, third flop finds the clock edge
    logic [7:0] s1_reg, s2_reg;
    logic lclk3_reg;
    logic smp, v_s, hub_s;
    logic [3:0] cmd_s;
    afw_pkg::afw_kind_t kind_s;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            lclk3_reg <= 1'b0;
        end else begin
            s1_reg <= {link_clk, link_req_valid, link_req_kind, link_req_cmd};
            s2_reg <= s1_reg;
            lclk3_reg <= s2_reg[7];
        end
    end
    always_comb begin
        smp = s2_reg[7] && !lclk3_reg;
        v_s = s2_reg[6];
        kind_s = afw_pkg::afw_kind_t'(s2_reg[5:4]);
        cmd_s = s2_reg[3:0];
    end
    logic hub1_reg, hub2_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hub1_reg <= 1'b0;
            hub2_reg <= 1'b0;
        end else begin
            hub1_reg <= link_req_hub;
            hub2_reg <= hub1_reg;
        end
    end
    assign hub_s = hub2_reg;

    ////////////////////////////////////////////////////////////////////////
    // command classification
    // returns {accepted, read, write, hipri}
    function automatic logic [3:0] afw_class(input afw_pkg::afw_kind_t k, input logic [3:0] c);
        logic [3:0] r;
        r = 4'h0;
        if (k == afw_pkg::AFW_FRAME) begin
            case (c)
                afw_pkg::FCMD_MRD, afw_pkg::FCMD_MRM, afw_pkg::FCMD_MRL: r = 4'hC;
                afw_pkg::FCMD_MWR, afw_pkg::FCMD_MWI: r = 4'hA;
                default: r = 4'h0;
            endcase
        end else if (k != afw_pkg::AFW_NONE) begin
            case (c)
                afw_pkg::CMD_READ, afw_pkg::CMD_LREAD: r = 4'hC;
                afw_pkg::CMD_HP_READ, afw_pkg::CMD_HP_LREAD: r = 4'hD;
                afw_pkg::CMD_WRITE: r = 4'hA;
                afw_pkg::CMD_HP_WRITE: r = 4'hB;
                default: r = 4'h0;
            endcase
        end
        return r;
    endfunction : afw_class

    afw_q_if #(.CW(CW)) qif ();
    afw_req_queue #(.DEPTH(QDEPTH), .CW(CW)) u_queue (
        .clk(clk),
        .rst_n(rst_n),
        .q(qif)
    );

    logic [3:0] cls;
    logic is_enh, is_flush, is_fence, push_v, reply_v, drop_v;
    afw_pkg::afw_req_t push_e;
    // one decision per sampled link edge; kinds interleave freely
    always_comb begin
        cls = afw_class(kind_s, cmd_s);
        is_enh = kind_s == afw_pkg::AFW_PIPE || kind_s == afw_pkg::AFW_SBA;
        is_flush = is_enh && cmd_s == afw_pkg::CMD_FLUSH;
        is_fence = is_enh && cmd_s == afw_pkg::CMD_FENCE;
        push_v = 1'b0;
        reply_v = 1'b0;
        drop_v = 1'b0;
        push_e = '0;
        push_e.write = cls[1];
        push_e.hipri = cls[0];
        push_e.snoop = kind_s == afw_pkg::AFW_FRAME;
        if (smp && v_s) begin
            if (is_fence) begin
                push_v = 1'b1; // ordering flag, no data
                push_e = '0;
                push_e.fence = 1'b1;
            end else if (is_flush) begin
                reply_v = 1'b1;
            end else if (!cls[3]) begin
                drop_v = 1'b1; // reserved: silent
            end else if (hub_s && kind_s == afw_pkg::AFW_FRAME) begin
                drop_v = 1'b1; // never forwarded to the hub
            end else if (hub_s && cls[2]) begin
                reply_v = 1'b1; // local random data
            end else if (hub_s) begin
                push_v = 1'b1; // memory cycle, byte enables off
                push_e.be_off = 1'b1;
            end else begin
                push_v = 1'b1;
            end
        end
    end
    assign qif.push_valid = push_v;
    assign qif.push_entry = push_e;
    assign link_stall = !qif.push_ready;

    // queue head drives memory in arrival order
    assign mem_req_valid = qif.pop_valid;
    assign qif.pop_ready = mem_req_ready;
    assign mem_req_write = qif.pop_entry.write;
    assign mem_req_hipri = qif.pop_entry.hipri;
    assign mem_req_snoop = qif.pop_entry.snoop;
    assign mem_req_be_off = qif.pop_entry.be_off;
    assign mem_req_fence = qif.fence_held;

    ////////////////////////////////////////////////////////////////////////
    // random data for locally completed reads
    logic [31:0] lfsr_reg, lfsr_next;
    logic rv_reg, rv_next;
    logic [63:0] rqw_reg, rqw_next;
    logic [15:0] drops_reg, drops_next;
    always_comb begin
        lfsr_next = {lfsr_reg[30:0], ^(lfsr_reg & afw_pkg::LFSR_TAPS)};
        rv_next = reply_v;
        rqw_next = reply_v ? {lfsr_reg, ~lfsr_reg} : rqw_reg;
        drops_next = drops_reg + 16'(drop_v);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= afw_pkg::LFSR_SEED;
            rv_reg <= 1'b0;
            rqw_reg <= 64'h0;
            drops_reg <= 16'h0;
        end else begin
            lfsr_reg <= lfsr_next;
            rv_reg <= rv_next;
            rqw_reg <= rqw_next;
            drops_reg <= drops_next;
        end
    end
    assign rdata_valid = rv_reg;
    assign rdata_qw = rqw_reg;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one ack a cycle after the request, unmapped reads zero
    logic fastwr_cap_reg, fastwr_cap_next, fastwr_en_reg, fastwr_en_next;
    logic [2:0] rate_reg, rate_next;
    logic lock_reg, lock_next, ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic wr_lo;
    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        wr_lo = ack_next && wb_we_i && wb_sel_i[0];
        fastwr_cap_next = fastwr_cap_reg;
        fastwr_en_next = fastwr_en_reg;
        rate_next = rate_reg;
        lock_next = lock_reg;
        dat_next = 32'h0;
        if (wr_lo && wb_adr_i == afw_pkg::OFF_CTRL) begin
            fastwr_cap_next = wb_dat_i[afw_pkg::CTRL_FASTWR_CAP_BIT];
        end
        if (wr_lo && wb_adr_i == afw_pkg::OFF_CMD) begin
            fastwr_en_next = wb_dat_i[afw_pkg::CMD_FASTWR_EN_BIT];
            if (!lock_reg) begin
                rate_next = wb_dat_i[afw_pkg::RATE_W-1:0]; // set once at init
                lock_next = |wb_dat_i[afw_pkg::RATE_W-1:0];
            end
        end
        if (ack_next && !wb_we_i) begin
            case (wb_adr_i)
                afw_pkg::OFF_CTRL: dat_next[afw_pkg::CTRL_FASTWR_CAP_BIT] = fastwr_cap_reg;
                afw_pkg::OFF_CMD: begin
                    dat_next[afw_pkg::RATE_W-1:0] = rate_reg;
                    dat_next[afw_pkg::CMD_FASTWR_EN_BIT] = fastwr_en_reg;
                end
                afw_pkg::OFF_STAT: begin
                    dat_next[afw_pkg::RATE_W-1:0] = afw_pkg::RATE_CAPS;
                    dat_next[afw_pkg::STAT_FASTWR_BIT] = fastwr_cap_reg;
                end
                afw_pkg::OFF_QSTAT: begin
                    dat_next[CW-1:0] = qif.count;
                    dat_next[afw_pkg::QSTAT_FENCE_BIT] = qif.fence_held;
                    dat_next[afw_pkg::QSTAT_DROP_LSB +: 16] = drops_reg;
                end
                default: dat_next = 32'h0;
            endcase
        end
    end
    // capability enable starts cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastwr_cap_reg <= 1'b0;
            fastwr_en_reg <= 1'b0;
            rate_reg <= afw_pkg::RATE_RESET;
            lock_reg <= 1'b0;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            fastwr_cap_reg <= fastwr_cap_next;
            fastwr_en_reg <= fastwr_en_next;
            rate_reg <= rate_next;
            lock_reg <= lock_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////////////
    // transfer rate and strobes; control protocol unchanged across rates
    function automatic logic [1:0] afw_mode(input logic [2:0] r);
        if (r[afw_pkg::RATE_4X_BIT]) begin
            return afw_pkg::AFW_W4X;
        end else if (r[afw_pkg::RATE_2X_BIT]) begin
            return afw_pkg::AFW_W2X;
        end
        return afw_pkg::AFW_W1X;
    endfunction : afw_mode
    // rate decode drives width and strobe outputs
    always_comb begin
        xfer_mode = afw_mode(rate_reg);
        strobe_comp_en = rate_reg[afw_pkg::RATE_4X_BIT] ? 3'h7 : 3'h0;
        block_bytes = afw_pkg::BLOCK_BYTES;
        case (xfer_mode)
            afw_pkg::AFW_W4X: xfer_bytes = afw_pkg::BPC_4X;
            afw_pkg::AFW_W2X: xfer_bytes = afw_pkg::BPC_2X;
            default: xfer_bytes = afw_pkg::BPC_1X;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // outbound writes: always frame cycles, fast write only when enabled
    logic fastwr_on;
    logic wv_reg, wv_next, wh_reg, wh_next;
    logic [1:0] wm_reg, wm_next;
    always_comb begin
        fastwr_on = fastwr_cap_reg && fastwr_en_reg && !rate_reg[afw_pkg::RATE_1X_BIT];
        wv_next = wr_in_valid; // processor or hub source alike
        wh_next = wr_in_from_hub;
        wm_next = fastwr_on ? afw_mode(rate_reg) : afw_pkg::AFW_W1X;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wv_reg <= 1'b0;
            wh_reg <= 1'b0;
            wm_reg <= afw_pkg::AFW_W1X;
        end else begin
            wv_reg <= wv_next;
            wh_reg <= wh_next;
            wm_reg <= wm_next;
        end
    end
    assign wr_out_valid = wv_reg;
    assign wr_out_from_hub = wh_reg;
    assign wr_out_mode = wm_reg;
    assign wr_out_frame = 1'b1; // no enhanced cycles as initiator

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_flush_seen;
        smp && v_s && is_enh && cmd_s == afw_pkg::CMD_FLUSH;
    endsequence
    sequence s_reply_out;
        rdata_valid && rdata_qw != 64'h0;
    endsequence
    no_snoop_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_v && is_enh |-> !push_e.snoop) else $error("enhanced request snooped");
    frame_snoop_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_v && kind_s == afw_pkg::AFW_FRAME |-> push_e.snoop) else $error("frame not snooped");
    hub_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_v && hub_s && !push_e.fence |-> push_e.be_off && push_e.write)
        else $error("hub write kept byte enables");
    hipri_a: assert property (@(posedge clk) disable iff (!rst_n)
        push_v && is_enh && (cmd_s == afw_pkg::CMD_HP_READ || cmd_s == afw_pkg::CMD_HP_LREAD)
        |-> push_e.hipri && !push_e.write) else $error("high priority read lost");
    flush_reply_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_flush_seen |-> !push_v ##1 s_reply_out) else $error("flush not answered");
    fence_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        smp && v_s && is_fence |-> qif.push_ready |-> push_e.fence ##1 !rdata_valid)
        else $error("fence handled wrongly");
    reserved_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
        smp && v_s && cls == 4'h0 && !is_flush && !is_fence |-> !push_v ##1 !rdata_valid)
        else $error("reserved command answered");
    fastwr_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(fastwr_cap_reg && fastwr_en_reg) ##1 wr_out_valid |-> wr_out_mode == afw_pkg::AFW_W1X)
        else $error("fast write without enables");
    rate_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        lock_reg |=> $stable(rate_reg)) else $error("rate changed after init");
endmodule : afw_target

// ===== verification/afw_gfx_master.sv
// graphics master model driving requests onto the link pins
`timescale 1ns/1ps
module afw_gfx_master (
    input wire logic clk,
    output logic link_clk,
    output logic link_req_valid,
    output logic [1:0] link_req_kind,
    output logic [3:0] link_req_cmd,
    output logic link_req_hub
);
    // link clock stands still between requests
    initial begin
        link_clk = 1'b0;
        link_req_valid = 1'b0;
        link_req_kind = 2'h3;
        link_req_cmd = 4'h0;
        link_req_hub = 1'b0;
    end
    // one request per 125 ns link period, pins held well around the rising edge
    task automatic send(input logic [1:0] k, input logic [3:0] c, input logic h);
        @(posedge clk);
        link_req_valid <= 1'b1;
        link_req_kind <= k;
        link_req_cmd <= c;
        link_req_hub <= h;
        #30 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
        #62.5;
        @(posedge clk);
        // released pins show the inverse so stale values never pass
        link_req_valid <= 1'b0;
        link_req_kind <= ~k;
        link_req_cmd <= ~c;
        link_req_hub <= ~h;
    endtask : send
endmodule : afw_gfx_master

// ===== verification/afw_target_tb_top.sv
// self-checking bench for the graphics-port target
`timescale 1ns/1ps
module afw_target_tb_top;
    logic clk, rst_n, cyc, stb, we, mem_req_ready, wr_in_valid, wr_in_from_hub, wb_ack_o, link_clk;
    logic link_req_valid, link_req_hub, rdata_valid, mem_req_valid, mem_req_write, mem_req_hipri;
    logic mem_req_snoop, mem_req_be_off, mem_req_fence, wr_out_valid, wr_out_from_hub, wr_out_frame;
    logic [1:0] link_req_kind, wr_out_mode, xfer_mode;
    logic link_stall;
    logic [3:0] link_req_cmd, sel;
    logic [7:0] adr;
    logic [31:0] dat, wb_dat_o;
    logic [63:0] rdata_qw, last_qw, note;
    logic [4:0] xfer_bytes;
    logic [6:0] block_bytes;
    logic [2:0] strobe_comp_en;
    logic [63:0] rd_q[$];
    logic [4:0] mem_q[$];
    logic [3:0] wr_q[$];
    int seed = 32'h77A09309;
    int rnd, fails = 0, comparisons = 0, replies = 0, exp_replies = 0, drops = 0;

    afw_target #(.QDEPTH(8)) uut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .link_clk, .link_req_valid,
        .link_req_kind, .link_req_cmd, .link_req_hub, .link_stall, .rdata_valid, .rdata_qw, .mem_req_valid,
        .mem_req_ready, .mem_req_write, .mem_req_hipri, .mem_req_snoop, .mem_req_be_off, .mem_req_fence,
        .wr_in_valid, .wr_in_from_hub, .wr_out_valid, .wr_out_from_hub, .wr_out_frame, .wr_out_mode,
        .xfer_mode, .xfer_bytes, .block_bytes, .strobe_comp_en);
    afw_gfx_master u_gm (.clk, .link_clk, .link_req_valid, .link_req_kind, .link_req_cmd, .link_req_hub);

    // clock and random memory-side backpressure
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        rnd = $random(seed);
        mem_req_ready <= rnd[0];
    end
    initial begin
        #200_000;
        fails++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fails++;
            wrap_up();
        end
        {cyc, stb, we} <= 3'h0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_q.push_back({m, e});
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse(input logic h, input logic [1:0] m);
        wr_q.push_back({h, 1'b1, m});
        @(posedge clk);
        {wr_in_valid, wr_in_from_hub} <= {1'b1, h};
        @(posedge clk);
        wr_in_valid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse
    // expected {push, reply, drop, head fields} for one link request
    function automatic logic [7:0] expect_of(input logic [1:0] k, input logic [3:0] c, input logic h);
        logic hp;
        hp = (c == 4'h1 || c == 4'h5 || c == 4'h9);
        if (k == 2'h0) return h ? 8'h20 : {4'h8, c[0], 3'b010};
        case (c)
            4'h0, 4'h1, 4'h8, 4'h9: return h ? 8'h40 : {5'h10, hp, 2'b00};
            4'h4, 4'h5: return {5'h11, hp, 1'b0, h};
            4'hA: return 8'h40;
            4'hC: return 8'h90;
            default: return 8'h20;
        endcase
    endfunction : expect_of
    task automatic link(input logic [1:0] k, input logic [3:0] c, input logic h);
        logic [7:0] e;
        e = expect_of(k, c, h);
        if (e[7]) mem_q.push_back(e[4:0]);
        exp_replies += e[6];
        drops += e[5];
        u_gm.send(k, c, h);
    endtask : link
    ////////////////////////////////////////////////////////////////////////////////
    // compare each read, memory request and outbound write against the oldest note of its kind
    always @(posedge clk) begin
        if (rst_n === 1'b1) begin
            if (wb_ack_o === 1'b1 && we === 1'b0) begin
                note = rd_q.pop_front();
                chk(wb_dat_o & note[63:32], note[31:0]);
            end
            if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) begin
                chk({27'h0, mem_req_fence, mem_req_write, mem_req_hipri, mem_req_snoop, mem_req_be_off},
                    {27'h0, mem_q.pop_front()});
            end
            if (wr_out_valid === 1'b1) chk({28'h0, wr_out_from_hub, wr_out_frame, wr_out_mode}, {28'h0, wr_q.pop_front()});
            if (rdata_valid === 1'b1) begin
                replies++;
                chk({31'h0, rdata_qw !== last_qw && rdata_qw !== 64'h0}, 32'h1);
                last_qw = rdata_qw;
            end
        end
    end
    // main sequence: registers, write protocol per rate, then link traffic
    initial begin
        {rst_n, cyc, stb, we, wr_in_valid, wr_in_from_hub, adr, sel, dat} = 50'h0;
        last_qw = 64'h0;
        do_reset();
        rd(afw_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h7);
        rd(afw_pkg::OFF_CTRL, 32'h1, 32'h0);
        rd(8'h20, 32'hFFFF_FFFF, 32'h0);
        pulse(1'b1, 2'h0);
        for (int r = 0; r < 3; r++) begin
            do_reset();
            wb(1'b1, afw_pkg::OFF_CTRL, 32'h1);
            rd(afw_pkg::OFF_STAT, 32'h17, 32'h17);
            wb(1'b1, afw_pkg::OFF_CMD, 32'h10 | (32'h1 << r));
            wb(1'b1, afw_pkg::OFF_CMD, 32'h10 | (32'h1 << ((r + 1) % 3)));
            rd(afw_pkg::OFF_CMD, 32'h17, 32'h10 | (32'h1 << r));
            chk({25'h0, block_bytes}, 32'h40);
            chk({27'h0, xfer_bytes}, 32'h4 << r);
            chk({30'h0, xfer_mode}, r);
            chk({29'h0, strobe_comp_en}, (r == 2) ? 32'h7 : 32'h0);
            pulse(1'b1, r[1:0]);
            pulse(1'b0, r[1:0]);
            wb(1'b1, afw_pkg::OFF_CMD, 32'h1 << r);
            pulse(1'b1, 2'h0);
        end
        for (int c = 0; c < 16; c++) for (int h = 0; h < 2; h++) for (int k = 0; k < 3; k++)
            link(k[1:0], (k == 0) ? {3'h3, c[0]} : c[3:0], h[0]);
        for (int n = 0; n < 2000 && mem_q.size() != 0; n++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(mem_q.size(), 0);
        chk({31'h0, link_stall}, 32'h0);
        chk(replies, exp_replies);
        rd(afw_pkg::OFF_QSTAT, 32'hFFFF_01FF, drops << 16);
        @(posedge clk);
        wrap_up();
    end
endmodule : afw_target_tb_top
